// ==== core/ampcd_top.sv ====
module ampcd_top import ampcd_pkg::*; (
  input wire logic MCLK, // Master clock
  input wire logic RST_N, // Asynchronous reset, active low
  input wire logic HIGH_RES_SELECT, // Power mode strap
  input wire logic FORMAT_SELECT, // Interface format strap
  input wire logic FRAME_ROLE_SELECT, // Frame role strap
  input wire logic [1:0] FILTER_SELECT, // Filter path strap
  input wire logic [1:0] DECIMATION_RATIO_SELECT, // Ratio strap
  input wire logic START, // Conversion run level
  input wire logic FRAME_STROBE, // Frame strobe from host, slave role
  output logic HIGH_RES_MODE, // High-resolution mode active
  output logic LOW_POWER_MODE, // Low-power mode active
  output logic SPI_MODE, // SPI interface selected
  output logic FRAME_MASTER, // Frame-sync master role selected
  output logic [1:0] FILTER_PATH, // Decoded filter path
  output logic [11:0] DECIMATION_RATIO, // Decoded ratio
  output logic CONFIG_RESET, // Internal reset pulse on change
  output logic MODULATOR_SAMPLE, // First modulator sample pulse
  output logic WORD_STROBE, // Output word pulse
  output logic DATA_READY_N, // Data ready, active low
  output logic DOUT_HOLD_LOW, // Data outputs forced low
  output logic FRAME_STROBE_OUT // Frame strobe driven in master role
);

  // ----------------------------------------------------------------
  // State of the whole block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] warm; // Power-up fill counter
    logic [CFG_W-1:0] cfg; // Applied strap image
    logic hr; // Decoded high-res
    logic spi; // Decoded SPI interface
    logic master; // Decoded frame master
    logic [1:0] filt; // Decoded filter path
    logic [11:0] ratio; // Decoded ratio
    ampcd_state_t st; // Sequencer state
    logic [11:0] cnt; // Delay or word counter
    logic [6:0] settle; // Words left before data settle
    logic [2:0] guard; // Cycles since last change
    logic fs_prev; // Frame strobe last cycle
    logic cfg_rst; // Reset pulse
    logic mod_smp; // First sample pulse
    logic word; // Word pulse
    logic data_ready_n_n; // Data ready, active low
    logic dout_low; // Data outputs held low
    logic fs_out; // Own frame strobe
  } ampcd_top_state_t;

  localparam ampcd_top_state_t S_RST = '{
    st: ST_IDLE,
    data_ready_n_n: DATA_READY_N_N_RST,
    dout_low: DOUT_LOW_RST,
    default: '0
  };

  ampcd_top_state_t s_ff; // Registered state
  ampcd_top_state_t nxt_s; // Next state
  logic changed; // Synced pins differ from applied image
  logic fs_rise; // Rising frame strobe from host
  logic guard_ok; // Frame edge may now be honoured

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  ampcd_pin_if pins ();

  assign pins.raw = {DECIMATION_RATIO_SELECT, FILTER_SELECT, FRAME_ROLE_SELECT, FORMAT_SELECT, HIGH_RES_SELECT};

  // Two flops ahead of decode and compare, one event per edge
  ampcd_sync #(
    .W(CFG_W)
  ) u_sync (
    .clk(MCLK),
    .rst_n(RST_N),
    .pins(pins)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------

  // Change detect, start control, sample delay and settle sequence
  always_comb begin
    nxt_s = s_ff;
    nxt_s.cfg_rst = 1'b0;
    nxt_s.mod_smp = 1'b0;
    nxt_s.word = 1'b0;
    nxt_s.fs_out = 1'b0;
    nxt_s.fs_prev = FRAME_STROBE;
    fs_rise = FRAME_STROBE & ~s_ff.fs_prev;
    changed = (pins.synced != s_ff.cfg);
    guard_ok = s_ff.master ? (s_ff.guard >= GUARD_MASTER) : (s_ff.guard >= GUARD_SLAVE);
    // Saturating count of cycles since the last change
    if (s_ff.guard != GUARD_SAT) begin
      nxt_s.guard = s_ff.guard + 3'h1;
    end
    if (s_ff.warm != WARM_CYC) begin
      // Power-up: adopt the straps silently while the synchroniser fills
      nxt_s.warm = s_ff.warm + 2'h1;
      nxt_s.cfg = pins.synced;
    end else if (changed) begin
      // Apply new straps on the third edge after the pin edge
      nxt_s.cfg = pins.synced;
      nxt_s.cfg_rst = 1'b1;
      nxt_s.guard = '0;
      nxt_s.data_ready_n_n = 1'b1;
      nxt_s.dout_low = 1'b1;
      nxt_s.cnt = FILT_DELAY_CYC - 12'h001;
      nxt_s.st = START ? ST_DELAY : ST_IDLE;
    end else if (!START) begin
      // Stopped: filter held in reset, outputs show no data
      nxt_s.st = ST_IDLE;
      nxt_s.data_ready_n_n = 1'b1;
      nxt_s.dout_low = 1'b1;
    end else begin
      unique case (s_ff.st)
        // Start just went high: restart the filter
        ST_IDLE: begin
          nxt_s.st = ST_DELAY;
          nxt_s.cnt = FILT_DELAY_CYC - 12'h001;
        end
        // Count down to the first modulator sample
        ST_DELAY: begin
          if (s_ff.cnt == 12'h000) begin
            nxt_s.mod_smp = 1'b1;
            nxt_s.cnt = s_ff.ratio - 12'h001;
            nxt_s.settle = (s_ff.filt == FILT_LL) ? LL_SETTLE_WORDS : WB_SETTLE_WORDS;
            nxt_s.st = s_ff.spi ? ST_SETTLE : ST_WAIT_FRAME;
          end else begin
            nxt_s.cnt = s_ff.cnt - 12'h001;
          end
        end
        // Frame mode: release filter on the first allowed frame edge
        ST_WAIT_FRAME: begin
          if (guard_ok && (s_ff.master || fs_rise)) begin
            nxt_s.st = ST_SETTLE;
            nxt_s.fs_out = s_ff.master;
            nxt_s.cnt = s_ff.ratio - 12'h001;
          end
        end
        // Words run; data withheld until the settle count expires
        ST_SETTLE: begin
          if (s_ff.cnt == 12'h000) begin
            nxt_s.cnt = s_ff.ratio - 12'h001;
            nxt_s.word = 1'b1;
            nxt_s.fs_out = s_ff.master;
            if (s_ff.settle == 7'h01) begin
              nxt_s.st = ST_RUN;
              nxt_s.data_ready_n_n = ~s_ff.spi;
              nxt_s.dout_low = 1'b0;
            end else begin
              nxt_s.settle = s_ff.settle - 7'h01;
            end
          end else begin
            nxt_s.cnt = s_ff.cnt - 12'h001;
          end
        end
        // Settled: one data-ready pulse per word in SPI mode; frame mode keeps data-ready high
        ST_RUN: begin
          nxt_s.data_ready_n_n = 1'b1;
          if (s_ff.cnt == 12'h000) begin
            nxt_s.cnt = s_ff.ratio - 12'h001;
            nxt_s.word = 1'b1;
            nxt_s.fs_out = s_ff.master;
            nxt_s.data_ready_n_n = ~s_ff.spi;
          end else begin
            nxt_s.cnt = s_ff.cnt - 12'h001;
          end
        end
      endcase
    end
    // Decode the applied image; reserved filter code runs as wideband 1
    nxt_s.hr = nxt_s.cfg[CFG_HR];
    nxt_s.spi = ~nxt_s.cfg[CFG_FMT];
    nxt_s.master = nxt_s.cfg[CFG_FMT] & nxt_s.cfg[CFG_ROLE];
    nxt_s.filt = (nxt_s.cfg[CFG_FILT +: 2] == FILT_RSV) ? FILT_WB1 : nxt_s.cfg[CFG_FILT +: 2];
    nxt_s.ratio = ampcd_ratio(nxt_s.filt, nxt_s.cfg[CFG_OSR +: 2]);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // Whole state in one register
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      s_ff <= S_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign HIGH_RES_MODE = s_ff.hr;
  assign LOW_POWER_MODE = ~s_ff.hr;
  assign SPI_MODE = s_ff.spi;
  assign FRAME_MASTER = s_ff.master;
  assign FILTER_PATH = s_ff.filt;
  assign DECIMATION_RATIO = s_ff.ratio;
  assign CONFIG_RESET = s_ff.cfg_rst;
  assign MODULATOR_SAMPLE = s_ff.mod_smp;
  assign WORD_STROBE = s_ff.word;
  assign DATA_READY_N = s_ff.data_ready_n_n;
  assign DOUT_HOLD_LOW = s_ff.dout_low;
  assign FRAME_STROBE_OUT = s_ff.fs_out;

endmodule : ampcd_top

// ==== pkg/ampcd_pkg.sv ====
package ampcd_pkg;

  // ----------------------------------------------------------------
  // Configuration pin bus layout
  // ----------------------------------------------------------------
  localparam int CFG_W = 7;              // Number of strap pins watched
  localparam int CFG_HR = 0;             // High-resolution select bit
  localparam int CFG_FMT = 1;            // Interface format bit
  localparam int CFG_ROLE = 2;           // Frame role bit
  localparam int CFG_FILT = 3;           // Filter select, two bits
  localparam int CFG_OSR = 5;            // Decimation select, two bits
  localparam int SYNC_STAGES = 2;        // Flops in the pin synchroniser

  // ----------------------------------------------------------------
  // Filter path codes
  // ----------------------------------------------------------------
  localparam logic [1:0] FILT_WB1 = 2'h0; // Wideband filter 1
  localparam logic [1:0] FILT_WB2 = 2'h1; // Wideband filter 2
  localparam logic [1:0] FILT_LL = 2'h2;  // Low-latency sinc filter
  localparam logic [1:0] FILT_RSV = 2'h3; // Reserved code

  // ----------------------------------------------------------------
  // Decimation ratios
  // ----------------------------------------------------------------
  localparam logic [11:0] WB_RATIO_0 = 12'h020; // 32
  localparam logic [11:0] WB_RATIO_1 = 12'h040; // 64
  localparam logic [11:0] WB_RATIO_2 = 12'h080; // 128
  localparam logic [11:0] WB_RATIO_3 = 12'h100; // 256
  localparam logic [11:0] LL_RATIO_0 = 12'h020; // 32
  localparam logic [11:0] LL_RATIO_1 = 12'h080; // 128
  localparam logic [11:0] LL_RATIO_2 = 12'h200; // 512
  localparam logic [11:0] LL_RATIO_3 = 12'h800; // 2048

  // ----------------------------------------------------------------
  // Timing counts in master-clock periods or output words
  // ----------------------------------------------------------------
  localparam logic [11:0] FILT_DELAY_CYC = 12'h004; // Change to first sample
  localparam logic [6:0] WB_SETTLE_WORDS = 7'h54;   // 84 words, wideband
  localparam logic [6:0] LL_SETTLE_WORDS = 7'h03;   // Low-latency settle
  localparam logic [2:0] GUARD_SLAVE = 3'h5;        // Change to frame edge
  localparam logic [2:0] GUARD_MASTER = 3'h1;       // Change to own frame
  localparam logic [2:0] GUARD_SAT = 3'h7;          // Guard counter ceiling
  localparam logic [1:0] WARM_CYC = 2'h3;           // Power-up fill, one past synchroniser depth

  // ----------------------------------------------------------------
  // Reset values of the outputs that idle high
  // ----------------------------------------------------------------
  localparam logic DATA_READY_N_N_RST = 1'b1;   // Data-ready idles inactive
  localparam logic DOUT_LOW_RST = 1'b1; // Data output idles held low

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DELAY,
    ST_WAIT_FRAME,
    ST_SETTLE,
    ST_RUN
  } ampcd_state_t;

  // Ratio lookup from filter path and decimation code
  function automatic logic [11:0] ampcd_ratio(input logic [1:0] filt, input logic [1:0] osr);
    logic [11:0] r;
    r = WB_RATIO_0;
    if (filt == FILT_LL) begin
      unique case (osr)
        2'h0: r = LL_RATIO_0;
        2'h1: r = LL_RATIO_1;
        2'h2: r = LL_RATIO_2;
        2'h3: r = LL_RATIO_3;
      endcase
    end else begin
      unique case (osr)
        2'h0: r = WB_RATIO_0;
        2'h1: r = WB_RATIO_1;
        2'h2: r = WB_RATIO_2;
        2'h3: r = WB_RATIO_3;
      endcase
    end
    return r;
  endfunction : ampcd_ratio

endpackage : ampcd_pkg

// ==== pkg/ampcd_pin_if.sv ====
interface ampcd_pin_if import ampcd_pkg::*; ();
  logic [CFG_W-1:0] raw;    // Strap pins as they arrive
  logic [CFG_W-1:0] synced; // Strap pins after the synchroniser
  modport sync_mp (input raw, output synced);
  modport use_mp (output raw, input synced);
endinterface : ampcd_pin_if

// ==== core/ampcd_sync.sv ====
module ampcd_sync import ampcd_pkg::*; #(
  parameter int W = CFG_W // Width of the pin bus
) (
  input wire logic clk, // Master clock
  input wire logic rst_n, // Asynchronous reset, active low
  ampcd_pin_if.sync_mp pins // Raw in, synchronised out
);

  // ----------------------------------------------------------------
  // Two-stage synchroniser state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] stage1; // First flop, read only by the second
    logic [W-1:0] stage2; // Second flop, safe to use
  } ampcd_sync_state_t;

  ampcd_sync_state_t s_ff; // Registered state
  ampcd_sync_state_t nxt_s; // Next state

  // Shift the pins through both stages
  always_comb begin
    nxt_s = s_ff;
    nxt_s.stage1 = pins.raw;
    nxt_s.stage2 = s_ff.stage1;
  end

  // Register the stages
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign pins.synced = s_ff.stage2; // Only the second stage leaves

endmodule : ampcd_sync

// ==== bench/ampcd_host_model.sv ====
module ampcd_host_model (
  input wire logic clk, // Master clock
  input wire logic rst_n, // Reset, low
  input wire logic run, // Frames wanted
  output logic strobe // Frame strobe to device
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_ff; // Frame spacing count
  // Frame timing, idle and still when not running
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 4'h0;
    end else begin
      cnt_ff <= run ? cnt_ff + 4'h1 : 4'h0;
    end
  end
  // One pulse every 16 cycles, keeps ample spacing from a change
  assign strobe = run && cnt_ff == 4'hf;
endmodule : ampcd_host_model

// ==== bench/ampcd_monitor.sv ====
module ampcd_monitor import ampcd_pkg::*; (
  input wire logic MCLK, // Clock
  input wire logic RST_N, // Reset
  input wire logic HIGH_RES_SELECT, // Strap
  input wire logic FORMAT_SELECT, // Strap
  input wire logic FRAME_ROLE_SELECT, // Strap
  input wire logic [1:0] FILTER_SELECT, // Strap
  input wire logic [1:0] DECIMATION_RATIO_SELECT, // Strap
  input wire logic START, // Run level
  input wire logic FRAME_STROBE, // Host strobe
  input wire logic HIGH_RES_MODE, // Decode
  input wire logic LOW_POWER_MODE, // Decode
  input wire logic SPI_MODE, // Decode
  input wire logic FRAME_MASTER, // Decode
  input wire logic [1:0] FILTER_PATH, // Decode
  input wire logic [11:0] DECIMATION_RATIO, // Decode
  input wire logic CONFIG_RESET, // Pulse
  input wire logic MODULATOR_SAMPLE, // Pulse
  input wire logic WORD_STROBE, // Pulse
  input wire logic DATA_READY_N, // Ready, low
  input wire logic DOUT_HOLD_LOW, // Data held
  input wire logic FRAME_STROBE_OUT // Own strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  logic [6:0] straps; // All straps as one word
  logic [2:0] age_ff; // Cycles since reset, saturating
  logic [11:0] gap_ff; // Cycles since last sample, release or word
  logic armed; // Power-up fill long over
  logic [2:0] guard_ff; // Cycles since last reset pulse, saturating
  logic fs_prev_ff; // Host strobe last cycle
  logic wait_ff; // Slave role: sampled, waiting for a frame edge
  logic rel_ff; // Slave release seen last cycle
  logic slave_wait; // Slave role waiting this cycle
  logic slave_rel; // Slave filter release this cycle
  assign straps = {DECIMATION_RATIO_SELECT, FILTER_SELECT, FRAME_ROLE_SELECT, FORMAT_SELECT, HIGH_RES_SELECT};
  assign armed = age_ff == 3'h7;
  assign slave_wait = wait_ff || (MODULATOR_SAMPLE && !SPI_MODE && !FRAME_MASTER);
  assign slave_rel = slave_wait && START && FRAME_STROBE && !fs_prev_ff && guard_ff >= GUARD_SLAVE;
  // Age, guard, slave release and word gap counters
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      age_ff <= 3'h0;
      gap_ff <= 12'h000;
      guard_ff <= 3'h0;
      fs_prev_ff <= 1'b0;
      wait_ff <= 1'b0;
      rel_ff <= 1'b0;
    end else begin
      age_ff <= armed ? age_ff : age_ff + 3'h1;
      guard_ff <= CONFIG_RESET ? 3'h1 : (guard_ff == GUARD_SAT ? guard_ff : guard_ff + 3'h1);
      fs_prev_ff <= FRAME_STROBE;
      wait_ff <= slave_wait && !slave_rel && !CONFIG_RESET && START;
      rel_ff <= slave_rel;
      gap_ff <= (MODULATOR_SAMPLE || WORD_STROBE || FRAME_STROBE_OUT || rel_ff) ? 12'h000 : gap_ff + 12'h001;
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  mode_decode_a: assert property ($stable(straps)[*4] ##0 armed |-> HIGH_RES_MODE == HIGH_RES_SELECT
    && LOW_POWER_MODE != HIGH_RES_SELECT && SPI_MODE != FORMAT_SELECT && FRAME_MASTER == (FORMAT_SELECT && FRAME_ROLE_SELECT))
    else $error("mode decode wrong");
  ratio_decode_a: assert property ($stable(straps)[*4] ##0 armed |-> FILTER_PATH == (&FILTER_SELECT ? 2'h0 : FILTER_SELECT)
    && DECIMATION_RATIO == (FILTER_SELECT == 2'h2 ? 12'h020 << (2 * DECIMATION_RATIO_SELECT) : 12'h020 << DECIMATION_RATIO_SELECT))
    else $error("ratio decode wrong");
  change_reset_a: assert property (armed && straps != $past(straps) |-> ##3 CONFIG_RESET)
    else $error("no reset after strap change");
  single_reset_a: assert property (CONFIG_RESET |-> $past(straps, 3) != $past(straps, 4))
    else $error("reset without one strap change");
  hold_on_change_a: assert property (CONFIG_RESET |-> DATA_READY_N && DOUT_HOLD_LOW)
    else $error("outputs not held at change");
  ready_fall_a: assert property ($fell(DATA_READY_N) |-> WORD_STROBE && SPI_MODE && !DOUT_HOLD_LOW)
    else $error("ready without settled word");
  sample_delay_a: assert property (CONFIG_RESET && START ##1 (START && !CONFIG_RESET)[*3] ##1 !CONFIG_RESET |-> MODULATOR_SAMPLE)
    else $error("first sample late or early");
  word_rate_a: assert property (WORD_STROBE |-> gap_ff == DECIMATION_RATIO - 12'h001)
    else $error("word spacing wrong");
  stop_run_a: assert property (!START |=> DATA_READY_N && DOUT_HOLD_LOW && !WORD_STROBE && !FRAME_STROBE_OUT)
    else $error("activity while stopped");
  master_strobe_a: assert property (FRAME_STROBE_OUT |-> FRAME_MASTER && !SPI_MODE)
    else $error("own strobe outside master role");
endmodule : ampcd_monitor
bind ampcd_top ampcd_monitor mon (.*);

// ==== bench/tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic MCLK = 1'b0; // Master clock
  logic RST_N = 1'b0; // Reset, low
  logic hr = 1'b0, fmt = 1'b0, role = 1'b0, START = 1'b1, frame_run = 1'b0; // Driven pins
  logic [1:0] filt = 2'h0, osr = 2'h0; // Driven strap pairs
  logic hrm, lpm, spi, fmst, cfg_rst, msamp, word, data_ready_n_n, hold, fso, fstrobe; // Observed
  logic [1:0] path; // Observed path
  logic [11:0] ratio; // Observed ratio
  int fails = 0;
  int compares = 0;
  ampcd_top dut (.MCLK(MCLK), .RST_N(RST_N), .HIGH_RES_SELECT(hr), .FORMAT_SELECT(fmt), .FRAME_ROLE_SELECT(role),
    .FILTER_SELECT(filt), .DECIMATION_RATIO_SELECT(osr), .START(START), .FRAME_STROBE(fstrobe), .HIGH_RES_MODE(hrm),
    .LOW_POWER_MODE(lpm), .SPI_MODE(spi), .FRAME_MASTER(fmst), .FILTER_PATH(path), .DECIMATION_RATIO(ratio),
    .CONFIG_RESET(cfg_rst), .MODULATOR_SAMPLE(msamp), .WORD_STROBE(word), .DATA_READY_N(data_ready_n_n),
    .DOUT_HOLD_LOW(hold), .FRAME_STROBE_OUT(fso));
  ampcd_host_model host (.clk(MCLK), .rst_n(RST_N), .run(frame_run), .strobe(fstrobe));
  // Clock, fast stand-in; mode frequency ceilings not modelled
  initial begin
    forever #2 MCLK = ~MCLK;
  end
  // Value comparison
  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check
  // Change straps, wait for the reset pulse, check decodes
  task automatic apply(input logic [6:0] s);
    int n;
    @(posedge MCLK); // Let an earlier reset pulse end
    @(negedge MCLK);
    {osr, filt, role, fmt, hr} = s;
    n = 0;
    while (cfg_rst !== 1'b1 && n < 8) begin
      @(posedge MCLK);
      #1;
      n++;
    end
    check("change latency", 12'h003, 12'(n));
    check("mode", 12'({hr, ~hr, ~fmt, fmt & role}), 12'({hrm, lpm, spi, fmst}));
    check("path", 12'(&filt ? 2'h0 : filt), 12'(path));
    check("ratio", filt == 2'h2 ? 12'h020 << (2 * osr) : 12'h020 << osr, ratio);
    check("held", 12'h003, 12'({data_ready_n_n, hold}));
  endtask : apply
  // Run until settled, counting words, ready lows and own strobes
  task automatic settle(input string name, input int words, input int bound);
    int n, w, lows, fs;
    n = 0;
    w = 0;
    lows = 0;
    fs = 0;
    while (hold !== 1'b0 && n < bound) begin
      @(posedge MCLK);
      #1;
      n++;
      w += int'(word === 1'b1);
      lows += int'(data_ready_n_n === 1'b0);
      fs += int'(fso === 1'b1);
    end
    check("words to settle", 12'(words), 12'(w));
    check("ready lows", 12'(spi === 1'b1), 12'(lows));
    check("own strobes", fmst === 1'b1 ? 12'(words + 1) : 12'h000, 12'(fs));
    $display("test %s done", name);
  endtask : settle
  // Verdict
  task automatic give_verdict();
    $display("compares %0d, fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict
  // Watchdog
  initial begin
    repeat (12000) @(posedge MCLK);
    fails++;
    give_verdict();
  end
  // Test sequence
  initial begin
    repeat (8) @(negedge MCLK);
    check("reset outputs", 12'h003, 12'({cfg_rst, data_ready_n_n, hold}));
    RST_N = 1'b1;
    repeat (6) @(negedge MCLK);
    for (int i = 0; i < 16; i++) begin
      apply({2'(i), 2'((i >> 2) % 3), i[0], i[1], ~i[0]});
    end
    $display("test decode done");
    apply({2'h0, 2'h2, 1'b0, 1'b0, 1'b1});
    settle("spi low latency", 3, 300);
    @(negedge MCLK);
    START = 1'b0; // Stop and restart after the filter change
    repeat (3) @(negedge MCLK);
    check("stopped", 12'h003, 12'({word, data_ready_n_n, hold}));
    START = 1'b1;
    settle("restart", 3, 300);
    @(negedge MCLK);
    RST_N = 1'b0; // Reset pulse keeps the device in step
    repeat (8) @(negedge MCLK);
    check("reset again", 12'h003, 12'({cfg_rst, data_ready_n_n, hold}));
    RST_N = 1'b1;
    repeat (6) @(negedge MCLK);
    $display("test mid-run reset done");
    apply({2'h0, 2'h0, 1'b0, 1'b0, 1'b1});
    settle("spi wideband", 84, 3000);
    apply({2'h0, 2'h2, 1'b1, 1'b1, 1'b0});
    settle("frame master", 3, 300);
    @(negedge MCLK);
    frame_run = 1'b1;
    apply({2'h0, 2'h2, 1'b0, 1'b1, 1'b0});
    settle("frame slave", 3, 400);
    frame_run = 1'b0;
    give_verdict();
  end
endmodule : tb
